// [logic/tsr_readout.v]
// Notes on behaviour
// - temperature sits left justified in bits 15..6
// - two's complement, one lsb is half degree
// - range +255.5 down to -256 degrees
// - bits 3..2 name the measured sensor
// - index 0 local, 1 and 2 remote
// - remote result flags diode fault in bit 1
// - diode fault loads temperature code 200h
// - local result always reads bit 1 zero
// - reserved result and control bits read zero
// - reset clears control register entirely
// - control bit 0 gates attention requests
// - attention needs some sensor enable set too
// - control bit 1 enables local sensor
// - control bit 2 enables remote sensor one
// - control bit 3 enables remote sensor two
// - scan enabled sensors ascending, round robin
// - new result sets flag, result read clears
// - unread result overwritten sets overrun flag
`timescale 1ns/10ps
`include "tsr_regs.vh"

module tsr_readout
(
  input  wire                   clk_i,
  input  wire                   arst_n_i,
  // register port as seen from the serial bus engine
  input  wire [`TSR_ADDR_W-1:0] reg_addr_i,
  input  wire                   reg_rd_i,
  input  wire                   reg_wr_i,
  input  wire [15:0]            reg_wdata_i,
  output reg  [15:0]            reg_rdata_o,
  output reg                    reg_rvalid_o,
  // conversion front end
  output reg                    conv_start_o,
  output reg  [1:0]             conv_sensor_o,
  input  wire                   conv_done_i,
  input  wire [9:0]             conv_temp_i,
  input  wire                   conv_fault_i,
  // status towards the bus engine
  output reg                    new_result_flag_o,
  output reg                    overrun_error_flag_o,
  output reg                    attention_req_o,
  output wire                   local_sensor_enable_o,
  output wire                   remote1_sensor_enable_o,
  output wire                   remote2_sensor_enable_o,
  output wire                   attention_enable_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  // reset synchroniser, release is clocked
  // both flops drop at once; only the release waits two edges
  reg        rst_s1_q;
  reg        rst_n_q;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // control register: bit0 attention, bits 3..1 sensor enables
  reg  [3:0]  ctrl_q;
  wire        rd_result;
  wire        wr_ctrl;
  reg  [3:0]  ctrl_d;
  wire [2:0]  sensor_en;
  wire        attn_en;

  // an unmapped index decodes to nothing, so writes there are dropped
  assign rd_result = reg_rd_i && (reg_addr_i == `TSR_RESULT_ADDR);
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == `TSR_CONTROL_ADDR);
  assign sensor_en = ctrl_q[`TSR_EN_MSB:`TSR_EN_LSB];
  assign attn_en   = ctrl_q[`TSR_ATTN_BIT];

  assign local_sensor_enable_o   = sensor_en[0];
  assign remote1_sensor_enable_o = sensor_en[1];
  assign remote2_sensor_enable_o = sensor_en[2];
  assign attention_enable_o      = attn_en;

  // only the low nibble is kept; the upper bits are reserved
  always @*
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = reg_wdata_i[3:0];
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ctrl_q <= `TSR_CONTROL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // round robin pick of the next enabled sensor after the last one
  // a lone enabled sensor is picked again right after itself
  reg  [1:0]  last_q;
  reg  [1:0]  next_sensor;
  reg         next_valid;

  always @*
  begin
    next_sensor = `TSR_SENSOR_LOCAL;
    next_valid  = 1'b1;
    case (last_q)
      `TSR_SENSOR_LOCAL:
      begin
        if (sensor_en[1])
          next_sensor = `TSR_SENSOR_REMOTE1;
        else if (sensor_en[2])
          next_sensor = `TSR_SENSOR_REMOTE2;
        else if (sensor_en[0])
          next_sensor = `TSR_SENSOR_LOCAL;
        else
          next_valid = 1'b0;
      end
      `TSR_SENSOR_REMOTE1:
      begin
        if (sensor_en[2])
          next_sensor = `TSR_SENSOR_REMOTE2;
        else if (sensor_en[0])
          next_sensor = `TSR_SENSOR_LOCAL;
        else if (sensor_en[1])
          next_sensor = `TSR_SENSOR_REMOTE1;
        else
          next_valid = 1'b0;
      end
      default:
      begin
        if (sensor_en[0])
          next_sensor = `TSR_SENSOR_LOCAL;
        else if (sensor_en[1])
          next_sensor = `TSR_SENSOR_REMOTE1;
        else if (sensor_en[2])
          next_sensor = `TSR_SENSOR_REMOTE2;
        else
          next_valid = 1'b0;
      end
    endcase
  end

  // conversion sequencer; one conversion outstanding at a time
  reg         state_q;
  reg         state_d;
  reg  [1:0]  last_d;
  reg         start_d;
  reg  [1:0]  sensor_d;
  wire        store;

  // a done pulse while idle belongs to nothing and is ignored
  assign store = (state_q == ST_CONV) && conv_done_i;

  always @*
  begin
    state_d  = state_q;
    last_d   = last_q;
    start_d  = 1'b0;
    sensor_d = conv_sensor_o;
    case (state_q)
      ST_IDLE:
      begin
        if (next_valid)
        begin
          start_d  = 1'b1;
          sensor_d = next_sensor;
          last_d   = next_sensor;
          state_d  = ST_CONV;
        end
      end
      ST_CONV:
      begin
        // a conversion in flight finishes even if its enable drops
        if (conv_done_i)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // last parks on the top index so the scan opens at the lowest
  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q       <= ST_IDLE;
      last_q        <= `TSR_SENSOR_REMOTE2;
      conv_start_o  <= 1'b0;
      conv_sensor_o <= `TSR_SENSOR_LOCAL;
    end
    else
    begin
      state_q       <= state_d;
      last_q        <= last_d;
      conv_start_o  <= start_d;
      conv_sensor_o <= sensor_d;
    end
  end

  // result register, every field written in the same edge
  reg  [9:0]  temp_q;
  reg  [9:0]  temp_d;
  reg  [1:0]  sensor_idx_q;
  reg  [1:0]  sensor_idx_d;
  reg         fault_q;
  reg         fault_d;
  wire        is_remote;
  wire        diode_fault;

  assign is_remote   = (conv_sensor_o != `TSR_SENSOR_LOCAL);
  // the local channel has no diode, so its fault input is ignored
  assign diode_fault = is_remote && conv_fault_i;

  always @*
  begin
    temp_d       = temp_q;
    sensor_idx_d = sensor_idx_q;
    fault_d      = fault_q;
    if (store)
    begin
      sensor_idx_d = conv_sensor_o;
      fault_d      = diode_fault;
      if (diode_fault)
        temp_d = `TSR_FAULT_TEMP;
      else
        temp_d = conv_temp_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      temp_q       <= 10'h000;
      sensor_idx_q <= `TSR_SENSOR_LOCAL;
      fault_q      <= 1'b0;
    end
    else
    begin
      temp_q       <= temp_d;
      sensor_idx_q <= sensor_idx_d;
      fault_q      <= fault_d;
    end
  end

  // status flags; a store in the read cycle keeps the flag set
  reg         new_flag_d;
  reg         overrun_d;
  reg         attn_req_d;

  always @*
  begin
    new_flag_d = new_result_flag_o;
    overrun_d  = overrun_error_flag_o;
    // gated at store time, so a later enable change cannot recall it
    attn_req_d = store && attn_en && (|sensor_en);
    if (store)
      new_flag_d = 1'b1;
    else if (rd_result)
      new_flag_d = 1'b0;
    // the read in the store cycle fetched the old result, so no loss
    if (store && new_result_flag_o && !rd_result)
      overrun_d = 1'b1;
    else if (rd_result)
      overrun_d = 1'b0;
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      new_result_flag_o    <= 1'b0;
      overrun_error_flag_o <= 1'b0;
      attention_req_o      <= 1'b0;
    end
    else
    begin
      new_result_flag_o    <= new_flag_d;
      overrun_error_flag_o <= overrun_d;
      attention_req_o      <= attn_req_d;
    end
  end

  // read data registered one cycle after the strobe
  reg  [15:0] rd_mux;
  reg  [15:0] rdata_d;

  always @*
  begin
    rd_mux = 16'h0000;
    case (reg_addr_i)
      `TSR_RESULT_ADDR:
      begin
        rd_mux[`TSR_TEMP_MSB:`TSR_TEMP_LSB] = temp_q;
        rd_mux[`TSR_SIDX_MSB:`TSR_SIDX_LSB] = sensor_idx_q;
        rd_mux[`TSR_FAULT_BIT]              = fault_q;
      end
      `TSR_CONTROL_ADDR:
        rd_mux[3:0] = ctrl_q;
      default:
        // unmapped indices read as zero
        rd_mux = 16'h0000;
    endcase
  end

  // data holds between reads so a slow bus engine may fetch it late
  always @*
  begin
    rdata_d = reg_rdata_o;
    if (reg_rd_i)
      rdata_d = rd_mux;
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      reg_rdata_o  <= `TSR_RESULT_RESET;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o  <= rdata_d;
      reg_rvalid_o <= reg_rd_i;
    end
  end

endmodule // tsr_readout

// [logic/tsr_regs.vh]
`ifndef TSR_REGS_VH
`define TSR_REGS_VH

// register indices on the sensor bus register port
`define TSR_ADDR_W          6
`define TSR_RESULT_ADDR     6'h09
`define TSR_CONTROL_ADDR    6'h0A

// result register layout
`define TSR_TEMP_MSB        15
`define TSR_TEMP_LSB        6
`define TSR_SIDX_MSB        3
`define TSR_SIDX_LSB        2
`define TSR_FAULT_BIT       1

// control register layout
`define TSR_ATTN_BIT        0
`define TSR_EN_LSB          1
`define TSR_EN_MSB          3

// reset values
`define TSR_CONTROL_RESET   4'h0
`define TSR_RESULT_RESET    16'h0000

// sensor indices and the fault code
`define TSR_SENSOR_LOCAL    2'h0
`define TSR_SENSOR_REMOTE1  2'h1
`define TSR_SENSOR_REMOTE2  2'h2
`define TSR_FAULT_TEMP      10'h200

`endif

// [test/tsr_front_model.sv]
`timescale 1ns/10ps
module tsr_front_model (
  input  wire        clk_i,
  input  wire        start_i,
  input  wire [1:0]  sel_i,
  input  wire [4:0]  dly_i,
  input  wire [29:0] temps_i,
  input  wire [2:0]  fault_i,
  output reg         done_o = 1'b0,
  output reg  [9:0]  temp_o = 10'h000,
  output reg         fault_o = 1'b0
);
  reg [4:0] cnt_q = 5'h00;
  reg [1:0] sel_q = 2'h0;
  // data toggles outside done so stale values never pass
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    temp_o <= ~temp_o;
    fault_o <= ~fault_o;
    if (start_i)
    begin
      cnt_q <= dly_i;
      sel_q <= sel_i;
    end
    else if (cnt_q == 5'h01)
    begin
      done_o <= 1'b1;
      temp_o <= temps_i[sel_q*10 +: 10];
      fault_o <= fault_i[sel_q];
      cnt_q <= 5'h00;
    end
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
  end
endmodule // tsr_front_model

// [test/tsr_readout_monitor.sv]
`timescale 1ns/10ps
module tsr_readout_monitor (
  input wire        clk_i,
  input wire        arst_n_i,
  input wire [5:0]  reg_addr_i,
  input wire        reg_rd_i,
  input wire        reg_wr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  input wire        conv_start_o,
  input wire [1:0]  conv_sensor_o,
  input wire        conv_done_i,
  input wire        new_result_flag_o,
  input wire        overrun_error_flag_o,
  input wire        attention_req_o,
  input wire        local_sensor_enable_o,
  input wire        remote1_sensor_enable_o,
  input wire        remote2_sensor_enable_o,
  input wire        attention_enable_o
);
  wire [2:0] en = {remote2_sensor_enable_o, remote1_sensor_enable_o,
                   local_sensor_enable_o};
  wire [3:0] ctl = {en, attention_enable_o};
  wire       rr = reg_rd_i && reg_addr_i == 6'h09;
  wire       rc = reg_rd_i && reg_addr_i == 6'h0A;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rsv;
    $past(rr) |-> reg_rdata_o[5:4] == 2'h0 && !reg_rdata_o[0];
  endproperty
  a_rsv: assert property (p_rsv) else $error("result spare bits");
  property p_loc;
    $past(rr) && reg_rdata_o[3:2] == 2'h0 |-> !reg_rdata_o[1];
  endproperty
  a_loc: assert property (p_loc) else $error("local flag");
  property p_flt;
    $past(rr) && reg_rdata_o[1] |->
      reg_rdata_o[15:6] == 10'h200 && reg_rdata_o[3:2] != 2'h0;
  endproperty
  a_flt: assert property (p_flt) else $error("fault code");
  property p_ctl;
    $past(rc) |-> reg_rdata_o == {12'h000, ctl};
  endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_wr;
    $past(reg_wr_i && reg_addr_i == 6'h0A) |-> ctl == $past(reg_wdata_i[3:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("control write");
  property p_att;
    attention_req_o |-> $past(attention_enable_o && en != 3'h0)
      && new_result_flag_o;
  endproperty
  a_att: assert property (p_att) else $error("attention");
  property p_clr;
    $past(rr && !conv_done_i) |->
      !new_result_flag_o && !overrun_error_flag_o;
  endproperty
  a_clr: assert property (p_clr) else $error("flags kept");
  property p_scan;
    conv_start_o |-> ($past(en) >> conv_sensor_o) & 3'h1;
  endproperty
  a_scan: assert property (p_scan) else $error("disabled scan");
  property p_rst;
    $rose(arst_n_i) |-> ctl == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("control reset");
endmodule // tsr_readout_monitor

// [test/tsr_readout_test.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tsr_readout_test;
  logic clk_i = 1'b0, arst_n_i, reg_rd_i, reg_wr_i, f;
  logic [5:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d, e;
  logic [9:0] conv_temp_i, t;
  logic [1:0] conv_sensor_o, s;
  logic [3:0] c;
  logic [4:0] dly;
  logic [29:0] temps;
  logic [2:0] fault;
  logic reg_rvalid_o, conv_start_o, conv_done_i, conv_fault_i;
  logic new_result_flag_o, overrun_error_flag_o, attention_req_o;
  logic local_sensor_enable_o, remote1_sensor_enable_o;
  logic remote2_sensor_enable_o, attention_enable_o;
  int i, n, errors, comparisons;
  logic [30:0] rows [5] = '{{4'h3, 10'h118, 1'b0, 16'h4600},
    {4'h5, 10'h3FF, 1'b0, 16'hFFC4}, {4'h9, 10'h0C8, 1'b1, 16'h800A},
    {4'h3, 10'h201, 1'b1, 16'h8040}, {4'h5, 10'h1FF, 1'b0, 16'h7FC4}};
  always #4 clk_i = ~clk_i;
  tsr_readout dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .conv_start_o(conv_start_o),
    .conv_sensor_o(conv_sensor_o), .conv_done_i(conv_done_i),
    .conv_temp_i(conv_temp_i), .conv_fault_i(conv_fault_i),
    .new_result_flag_o(new_result_flag_o),
    .overrun_error_flag_o(overrun_error_flag_o),
    .attention_req_o(attention_req_o),
    .local_sensor_enable_o(local_sensor_enable_o),
    .remote1_sensor_enable_o(remote1_sensor_enable_o),
    .remote2_sensor_enable_o(remote2_sensor_enable_o),
    .attention_enable_o(attention_enable_o));
  tsr_front_model fe (.clk_i(clk_i), .start_i(conv_start_o),
    .sel_i(conv_sensor_o), .dly_i(dly), .temps_i(temps), .fault_i(fault),
    .done_o(conv_done_i), .temp_o(conv_temp_i), .fault_o(conv_fault_i));
  task finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input [5:0] a, input [15:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [5:0] a, output [15:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    `CHK(reg_rvalid_o, 1'b1)
  endtask
  // bounded wait on a start (k=1) or an attention pulse (k=0)
  task wt(input k);
    for (n = 0; n < 300; n++)
    begin
      @(posedge clk_i);
      #1;
      if (k ? conv_start_o : attention_req_o)
        break;
    end
    if (n == 300)
    begin
      errors++;
      finish_test;
    end
  endtask
  task idle(input int k);
    wr(6'h0A, 16'h0000);
    repeat (k) @(posedge clk_i);
  endtask
  initial
  begin
    {arst_n_i, reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i} = '0;
    {dly, temps, fault} = {5'd20, 33'h0};
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 5; i++)
    begin
      {c, t, f, e} = rows[i];
      idle(40);
      temps <= {3{t}};
      fault <= {3{f}};
      wr(6'h0A, {12'h000, c});
      wt(0);
      rd(6'h09, d);
      `CHK(d, e)
    end
    dly <= 5'd1;
    for (i = 0; i < 2; i++)
    begin
      idle(40);
      wr(6'h0A, i ? 16'h000B : 16'h000F);
      wt(1);
      s = conv_sensor_o;
      repeat (4)
      begin
        wt(1);
        s = i ? 2'h2 - s : (s == 2'h2 ? 2'h0 : s + 2'h1);
        `CHK(conv_sensor_o, s)
        s = conv_sensor_o;
      end
    end
    idle(9);
    #1;
    `CHK({new_result_flag_o, overrun_error_flag_o}, 2'b11)
    rd(6'h09, d);
    `CHK({new_result_flag_o, overrun_error_flag_o}, 2'b00)
    wr(6'h0A, 16'h0001);
    repeat (20) @(posedge clk_i);
    #1;
    `CHK(new_result_flag_o, 1'b0)
    wr(6'h0A, 16'h0002);
    repeat (20) @(posedge clk_i);
    #1;
    `CHK(new_result_flag_o, 1'b1)
    wr(6'h0A, 16'hFFFF);
    rd(6'h0A, d);
    `CHK(d, 16'h000F)
    rd(6'h3F, d);
    `CHK(d, 16'h0000)
    arst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(6'h0A, d);
    `CHK(d, 16'h0000)
    finish_test;
  end
endmodule // tsr_readout_test
bind tsr_readout tsr_readout_monitor mon (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o),
  .conv_sensor_o(conv_sensor_o), .conv_done_i(conv_done_i),
  .new_result_flag_o(new_result_flag_o),
  .overrun_error_flag_o(overrun_error_flag_o),
  .attention_req_o(attention_req_o),
  .local_sensor_enable_o(local_sensor_enable_o),
  .remote1_sensor_enable_o(remote1_sensor_enable_o),
  .remote2_sensor_enable_o(remote2_sensor_enable_o),
  .attention_enable_o(attention_enable_o));
